/* sru_defines.svh */
// register offsets, reset values, count widths and last operation code of the shift unit
// assumes a 32-bit apb slave with word aligned registers
`ifndef SRU_DEFINES_SVH
`define SRU_DEFINES_SVH

`define SRU_OFF_EVEN      8'h00
`define SRU_OFF_ODD       8'h04
`define SRU_OFF_ARG       8'h08
`define SRU_OFF_CMD       8'h0c
`define SRU_OFF_RES_EVEN  8'h10
`define SRU_OFF_RES_ODD   8'h14
`define SRU_OFF_CC        8'h18

`define SRU_RST_WORD      16'h0000
`define SRU_RST_CC        4'h0

`define SRU_HALF_CNT_W    4
`define SRU_PAIR_CNT_W    5
`define SRU_OP_LAST       4'hb

`endif

/* sru_pkg.sv */
// types of the shift and rotate unit: operation codes and condition code
// assumes sru_defines.svh for numeric constants
`default_nettype none

package sru_pkg;

    typedef enum logic [3:0] {
        short_logical_left  = 4'h0,
        half_logical_left   = 4'h1,
        pair_logical_left   = 4'h2,
        short_logical_right = 4'h3,
        half_logical_right  = 4'h4,
        pair_logical_right  = 4'h5,
        pair_rotate_left    = 4'h6,
        pair_rotate_right   = 4'h7,
        half_arith_left     = 4'h8,
        pair_arith_left     = 4'h9,
        half_arith_right    = 4'ha,
        pair_arith_right    = 4'hb
    } sru_op_t;

    // condition code, carry in the top bit
    typedef struct packed {
        logic carry;
        logic ovf;
        logic greater;
        logic less;
    } sru_cc_t;

endpackage

`default_nettype wire

/* sru_shift_rotate_unit.sv */
// shift and rotate datapath of a 16-bit processor behind an apb slave
// assumes apb master on core_clk; decoder places count or effective address in the arg register
//
// Design decisions made here: the APB slave port and the register addresses.
`include "sru_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module sru_shift_rotate_unit (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    output sru_pkg::sru_cc_t ccOut
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0]      opEven;
    logic [15:0]      opOdd;
    logic [15:0]      arg;
    logic [15:0]      resEven;
    logic [15:0]      resOdd;
    sru_pkg::sru_op_t lastOp;
    logic [15:0]      next_opEven;
    logic [15:0]      next_opOdd;
    logic [15:0]      next_arg;
    logic [15:0]      next_resEven;
    logic [15:0]      next_resOdd;
    sru_pkg::sru_op_t next_lastOp;
    sru_pkg::sru_cc_t next_cc;
    logic             next_pready;
    logic [31:0]      next_prdata;
    logic             next_pslverr;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic             access;
    logic             wrEn;
    logic             exec;
    logic             mapped;
    sru_pkg::sru_op_t cmdOp;

    assign access = psel & penable & pready;
    assign wrEn   = access & pwrite;
    assign cmdOp  = sru_pkg::sru_op_t'(pwdata[3:0]);
    assign exec   = wrEn & (paddr == `SRU_OFF_CMD) & (pwdata[3:0] <= `SRU_OP_LAST);

    always_comb begin
        case (paddr)
            `SRU_OFF_EVEN, `SRU_OFF_ODD, `SRU_OFF_ARG, `SRU_OFF_CMD,
            `SRU_OFF_RES_EVEN, `SRU_OFF_RES_ODD, `SRU_OFF_CC: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // shifter
    // ------------------------------------------------------------
    logic [31:0] v;
    logic [4:0]  n;
    logic [32:0] w;
    logic [31:0] t;
    logic [63:0] rr;
    logic [31:0] r;
    logic        c;
    logic        isPair;
    logic        lowHalf;

    always_comb begin
        v       = {opEven, opOdd};
        n       = {1'b0, arg[3:0]};
        w       = 33'h0;
        t       = 32'h0;
        rr      = 64'h0;
        r       = v;
        c       = 1'b0;
        isPair  = 1'b0;
        lowHalf = 1'b0;
        case (cmdOp)
            sru_pkg::short_logical_left, sru_pkg::half_logical_left: begin
                v = {opEven, 16'h0000};
                w = {1'b0, v} << n;
                r = w[31:0];
                c = w[32];
            end
            // pair with carry from even end
            sru_pkg::pair_logical_left: begin
                n      = arg[4:0];
                isPair = 1'b1;
                w      = {1'b0, v} << n;
                r      = w[31:0];
                c      = w[32];
            end
            sru_pkg::short_logical_right, sru_pkg::half_logical_right: begin
                lowHalf = 1'b1;
                v       = {16'h0000, opEven};
                w       = {v, 1'b0} >> n;
                r       = w[32:1];
                c       = w[0];
            end
            sru_pkg::pair_logical_right: begin
                n      = arg[4:0];
                isPair = 1'b1;
                w      = {v, 1'b0} >> n;
                r      = w[32:1];
                c      = w[0];
            end
            sru_pkg::pair_rotate_left: begin
                n      = arg[4:0];
                isPair = 1'b1;
                rr     = {v, v} << n;
                r      = rr[63:32];
                c      = (n != 5'h00) & r[0];
            end
            sru_pkg::pair_rotate_right: begin
                n      = arg[4:0];
                isPair = 1'b1;
                rr     = {v, v} >> n;
                r      = rr[31:0];
                c      = (n != 5'h00) & r[31];
            end
            sru_pkg::half_arith_left, sru_pkg::pair_arith_left: begin
                if (cmdOp == sru_pkg::pair_arith_left) begin
                    n      = arg[4:0];
                    isPair = 1'b1;
                end else begin
                    v = {opEven, 16'h0000};
                end
                t = {1'b0, v[30:0]} << n;
                r = {v[31], t[30:0]};
                c = t[31];
            end
            sru_pkg::half_arith_right, sru_pkg::pair_arith_right: begin
                if (cmdOp == sru_pkg::pair_arith_right) begin
                    n      = arg[4:0];
                    isPair = 1'b1;
                end else begin
                    lowHalf = 1'b1;
                    v       = {{16{opEven[15]}}, opEven};
                end
                w = 33'($signed({v, 1'b0}) >>> n);
                r = w[32:1];
                c = w[0];
            end
            default: begin
                r = v;
            end
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic [15:0] halfRes;
    logic        zeroRes;
    logic        signRes;

    assign halfRes = lowHalf ? r[15:0] : r[31:16];
    assign zeroRes = isPair ? (r == 32'h0) : (halfRes == 16'h0000);
    assign signRes = isPair ? r[31] : halfRes[15];

    always_comb begin
        next_opEven  = opEven;
        next_opOdd   = opOdd;
        next_arg     = arg;
        next_resEven = resEven;
        next_resOdd  = resOdd;
        next_lastOp  = lastOp;
        next_cc      = ccOut;
        next_pready  = psel & penable & ~pready;
        next_prdata  = prdata;
        next_pslverr = 1'b0;
        if (wrEn) begin
            case (paddr)
                `SRU_OFF_EVEN: next_opEven = pwdata[15:0];
                `SRU_OFF_ODD:  next_opOdd  = pwdata[15:0];
                `SRU_OFF_ARG:  next_arg    = pwdata[15:0];
                default: next_arg = arg;
            endcase
        end
        if (exec) begin
            next_resEven  = isPair ? r[31:16] : halfRes;
            next_resOdd   = isPair ? r[15:0] : opOdd;
            next_lastOp   = cmdOp;
            next_cc.carry = c;
            next_cc.ovf   = 1'b0;
            next_cc.greater = ~zeroRes & ~signRes;
            next_cc.less    = ~zeroRes & signRes;
        end
        if (psel & penable & ~pready) begin
            next_pslverr = ~mapped | (pwrite & (paddr == `SRU_OFF_CMD)
                                      & (pwdata[3:0] > `SRU_OP_LAST));
            case (paddr)
                `SRU_OFF_EVEN:     next_prdata = {16'h0000, opEven};
                `SRU_OFF_ODD:      next_prdata = {16'h0000, opOdd};
                `SRU_OFF_ARG:      next_prdata = {16'h0000, arg};
                `SRU_OFF_CMD:      next_prdata = {28'h0, lastOp};
                `SRU_OFF_RES_EVEN: next_prdata = {16'h0000, resEven};
                `SRU_OFF_RES_ODD:  next_prdata = {16'h0000, resOdd};
                `SRU_OFF_CC:       next_prdata = {28'h0, ccOut};
                default:           next_prdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            opEven  <= `SRU_RST_WORD;
            opOdd   <= `SRU_RST_WORD;
            arg     <= `SRU_RST_WORD;
            resEven <= `SRU_RST_WORD;
            resOdd  <= `SRU_RST_WORD;
            lastOp  <= sru_pkg::short_logical_left;
            ccOut   <= `SRU_RST_CC;
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            opEven  <= next_opEven;
            opOdd   <= next_opOdd;
            arg     <= next_arg;
            resEven <= next_resEven;
            resOdd  <= next_resOdd;
            lastOp  <= next_lastOp;
            ccOut   <= next_cc;
            pready  <= next_pready;
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_zero_count;
        exec && arg[4:0] == 5'h00 |=> resEven == $past(opEven) && resOdd == $past(opOdd);
    endproperty
    a_zero_count: assert property (p_zero_count) else $error("zero count altered data");
    property p_sign_flags;
        exec |=> ccOut.less == resEven[15] && ccOut.greater == (!resEven[15]
            && (resEven != 16'h0000 || ($past(isPair) && resOdd != 16'h0000)));
    endproperty
    a_sign_flags: assert property (p_sign_flags) else $error("flags wrong for result");
    property p_short_left;
        exec && cmdOp == sru_pkg::short_logical_left
            |=> resEven == 16'($past(opEven) << $past(arg[3:0]));
    endproperty
    a_short_left: assert property (p_short_left) else $error("short left result wrong");
    property p_left_carry;
        exec && cmdOp == sru_pkg::half_logical_left && arg[3:0] == 4'h1
            |=> ccOut.carry == $past(opEven[15]) && resEven[0] == 1'b0;
    endproperty
    a_left_carry: assert property (p_left_carry) else $error("left carry wrong");
    property p_right_carry;
        exec && cmdOp == sru_pkg::half_logical_right && arg[3:0] == 4'h1
            |=> ccOut.carry == $past(opEven[0]) && resEven[15] == 1'b0;
    endproperty
    a_right_carry: assert property (p_right_carry) else $error("right carry wrong");
    property p_pair_left;
        exec && cmdOp == sru_pkg::pair_logical_left
            |=> {resEven, resOdd} == 32'({$past(opEven), $past(opOdd)} << $past(arg[4:0]));
    endproperty
    a_pair_left: assert property (p_pair_left) else $error("pair left result wrong");
    property p_rot_swap;
        exec && arg[4:0] == 5'h10 && (cmdOp == sru_pkg::pair_rotate_left
            || cmdOp == sru_pkg::pair_rotate_right)
            |=> resEven == $past(opOdd) && resOdd == $past(opEven);
    endproperty
    a_rot_swap: assert property (p_rot_swap) else $error("rotate sixteen did not swap");
    property p_arith_sign;
        exec && cmdOp == sru_pkg::half_arith_left |=> resEven[15] == $past(opEven[15]);
    endproperty
    a_arith_sign: assert property (p_arith_sign) else $error("arith left lost sign");
    property p_arith_right;
        exec && cmdOp == sru_pkg::half_arith_right
            |=> resEven == 16'($signed($past(opEven)) >>> $past(arg[3:0]));
    endproperty
    a_arith_right: assert property (p_arith_right) else $error("arith right wrong");
    property p_answer;
        psel && penable && !pready |=> pready ##1 !pready;
    endproperty
    a_answer: assert property (p_answer) else $error("apb answer timing wrong");
    c_rotate: cover property (exec && cmdOp == sru_pkg::pair_rotate_left);
    c_arith:  cover property (exec && cmdOp == sru_pkg::pair_arith_right ##1 ccOut.carry);
    c_error:  cover property (pready && pslverr);

endmodule

`default_nettype wire

/* sru_decoder_model.sv */
// decoder side model: drives apb transfers into the shift unit
// assumes one core_clk domain; caller starts each transfer at a rising edge
`timescale 1ns/100ps
`default_nettype none

module sru_decoder_model (
    input  wire logic        core_clk,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    output var logic         psel,
    output var logic         penable,
    output var logic         pwrite,
    output var logic [7:0]   paddr,
    output var logic [31:0]  pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end

    // ----------------------------------------
    // one transfer, bounded wait for ready
    // ----------------------------------------
    // register chosen by the caller through a
    // data goes to whichever register the paddr value names
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err, output bit ok);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        ok = 1'b0;
        for (i = 0; i < 20 && !ok; i++) begin
            @(posedge core_clk);
            if (pready === 1'b1) ok = 1'b1;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines no longer show the old value
        paddr <= ~a;
        pwdata <= ~d;
        @(posedge core_clk);
    endtask
endmodule

`default_nettype wire

/* sru_shift_rotate_unit_test.sv */
// self-checking bench of the shift unit against a bit-serial model
// assumes sru_defines.svh offsets and the decoder model for apb traffic
`include "sru_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module sru_shift_rotate_unit_test;
    logic             core_clk;
    logic             rst;
    logic             psel;
    logic             penable;
    logic             pwrite;
    logic [7:0]       paddr;
    logic [31:0]      pwdata;
    logic             pready;
    logic [31:0]      prdata;
    logic             pslverr;
    sru_pkg::sru_cc_t ccOut;
    int               error_cnt;
    int               n_checks;
    logic [15:0]      lastE;

    sru_shift_rotate_unit DUT (.core_clk(core_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .ccOut(ccOut));

    sru_decoder_model BUS (.core_clk(core_clk), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // ----------------------------------------
    // checks and closing
    // ----------------------------------------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmpFlag(input logic [3:0] got, input logic [3:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rw(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
        bit ok;
        BUS.xfer(wr, a, d, rd, err, ok);
        if (!ok) begin
            error_cnt++;
            $display("mismatch at %0t got %h expected %h", $time, 1'b0, 1'b1);
            stop_test();
        end
    endtask

    // ----------------------------------------
    // reference model, one bit per step
    // ----------------------------------------
    function automatic void model(input logic [3:0] op, input logic [15:0] e, o, a,
                                  output logic [15:0] re, ro, output logic [3:0] cc);
        int w;
        int n;
        int i;
        bit pr;
        logic c;
        logic [31:0] x;
        logic [31:0] sg;
        logic [31:0] msb;
        pr = op inside {4'h2, 4'h5, 4'h6, 4'h7, 4'h9, 4'hb};
        w = pr ? 32 : 16;
        n = pr ? int'(a[4:0]) : int'(a[3:0]);
        x = pr ? {e, o} : {16'h0000, e};
        msb = 32'h0000_0001 << (w - 1);
        sg = x & msb;
        c = 1'b0;
        for (i = 0; i < n; i++) begin
            case (op)
                4'h0, 4'h1, 4'h2: begin c = x[w-1]; x = x << 1; end
                4'h3, 4'h4, 4'h5: begin c = x[0]; x = x >> 1; end
                4'h6: begin c = x[w-1]; x = (x << 1) | {31'h0, c}; end
                4'h7: begin c = x[0]; x = (x >> 1) | ({31'h0, c} << 31); end
                4'h8, 4'h9: begin c = x[w-2]; x = ((x << 1) & ~msb) | sg; end
                default: begin c = x[0]; x = (x >> 1) | sg; end
            endcase
            if (w == 16) x = x & 32'h0000_ffff;
        end
        cc = {c, 1'b0, !x[w-1] && x != 32'h0, x[w-1]};
        re = pr ? x[31:16] : x[15:0];
        ro = pr ? x[15:0] : o;
    endfunction

    task automatic runOp(input logic [3:0] op, input logic [15:0] e, o, a);
        logic [31:0] rd;
        logic err;
        logic [15:0] re;
        logic [15:0] ro;
        logic [3:0] cc;
        model(op, e, o, a, re, ro, cc);
        lastE = re;
        rw(1'b1, `SRU_OFF_EVEN, {16'h0000, e}, rd, err);
        rw(1'b1, `SRU_OFF_ODD, {16'h0000, o}, rd, err);
        rw(1'b1, `SRU_OFF_ARG, {16'h0000, a}, rd, err);
        rw(1'b1, `SRU_OFF_CMD, {28'h0, op}, rd, err);
        cmpFlag(ccOut, cc);
        rw(1'b0, `SRU_OFF_RES_EVEN, 32'h0, rd, err);
        cmpWord(rd, {16'h0000, re});
        rw(1'b0, `SRU_OFF_RES_ODD, 32'h0, rd, err);
        cmpWord(rd, {16'h0000, ro});
        rw(1'b0, `SRU_OFF_CC, 32'h0, rd, err);
        cmpWord(rd, {28'h0, cc});
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        int op;
        int k;
        int cnt [5] = '{0, 1, 15, 16, 31};
        logic [31:0] rd;
        logic [15:0] a;
        logic err;
        error_cnt = 0;
        n_checks = 0;
        rst = 1'b1;
        void'($urandom(32'h1500));
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        cmpFlag(ccOut, `SRU_RST_CC);
        rw(1'b0, `SRU_OFF_RES_EVEN, 32'h0, rd, err);
        cmpWord(rd, {16'h0000, `SRU_RST_WORD});
        $display("reset test done");
        for (op = 0; op <= 11; op++) begin
            for (k = 0; k < 6; k++) begin
                a = 16'($urandom());
                if (k < 5) a[4:0] = 5'(cnt[k]);
                runOp(4'(op), 16'($urandom()), 16'($urandom()), a);
            end
        end
        runOp(4'h0, 16'h8421, 16'h1234, 16'h0010);
        runOp(4'ha, 16'h8001, 16'h0000, 16'hfff4);
        $display("operation test done");
        rw(1'b1, `SRU_OFF_CMD, 32'h0000_000c, rd, err);
        cmpWord({31'h0, err}, 32'h1);
        rw(1'b1, `SRU_OFF_RES_EVEN, 32'h0000_ffff, rd, err);
        cmpWord({31'h0, err}, 32'h0);
        rw(1'b0, `SRU_OFF_RES_EVEN, 32'h0, rd, err);
        cmpWord(rd, {16'h0000, lastE});
        rw(1'b0, `SRU_OFF_CMD, 32'h0, rd, err);
        cmpWord(rd, 32'h0000_000a);
        rw(1'b0, 8'h1c, 32'h0, rd, err);
        cmpWord({err, rd[30:0]}, 32'h8000_0000);
        $display("refusal test done");
        stop_test();
    end
endmodule

`default_nettype wire
